//--- rtl/cpacc_defines.svh
// Constants for the current and power accumulator engine.
`ifndef CPACC_DEFINES_SVH
`define CPACC_DEFINES_SVH
`define CPACC_AVG_W       3
`define CPACC_ACC_W       50
`define CPACC_RES_W       40
`define CPACC_CUR_SHIFT   11
`define CPACC_SEL_SHUNT   2'h0
`define CPACC_SEL_BUS     2'h1
`define CPACC_SEL_TEMP    2'h2
`define CPACC_MODE_OFF    2'h0
`define CPACC_MODE_SINGLE 2'h1
`define CPACC_MODE_CONT   2'h2
`define CPACC_CNT_W       11
`endif

//--- rtl/cpacc_pkg.sv
// Types shared by the current and power accumulator engine.
`include "cpacc_defines.svh"
package cpacc_pkg;
  // ----------------------------------------------------------------
  // Configuration carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]             mode;    // Off, single or continuous.
    logic                   en_shunt; // Shunt input enabled.
    logic                   en_bus;  // Bus input enabled.
    logic                   en_temp; // Temperature input enabled.
    logic [`CPACC_AVG_W-1:0] avg_sel; // Averaging count code.
    logic [15:0]            shunt_cal; // Shunt calibration value.
  } cpacc_cfg_t;
  // ----------------------------------------------------------------
  // Result carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [23:0] current; // Averaged current.
    logic [23:0] power;   // Averaged power.
  } cpacc_res_t;
endpackage : cpacc_pkg

//--- rtl/cpacc_mul.sv
// Registered signed multiplier, instanced twice by the arithmetic engine.
`timescale 1ns/1ps
module cpacc_mul (
  input  wire logic               CLK_SYS, // System clock.
  input  wire logic               NRST,    // Asynchronous reset, low.
  input  wire logic               go,      // Start a product.
  input  wire logic signed [23:0] a,       // First operand.
  input  wire logic signed [23:0] b,       // Second operand.
  output logic signed [47:0]      p_reg,   // Registered product.
  output logic                    done_reg // Product valid pulse.
);
  // ----------------------------------------------------------------
  // Product register
  // ----------------------------------------------------------------
  // One cycle of latency keeps the multiply off the accumulate path.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      p_reg    <= 48'sh0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= go;
      if (go) begin
        p_reg <= a * b;
      end
    end
  end
endmodule : cpacc_mul

//--- rtl/cpacc_engine.sv
// Background current and power arithmetic with averaging.
// How it works
// RULE_01: Compute after shunt and bus both done.
// RULE_02: Power is previous current times latest bus.
// RULE_03: Zero calibration gives zero power.
// RULE_04: Averaging above one keeps results internal.
// RULE_05: Add each sample into accumulators.
// RULE_06: Load averages when block completes.
// RULE_07: Arithmetic runs beside conversions, adds nothing.
// RULE_08: One converter, inputs selected one at time.
// RULE_09: Mode selects continuous or single sequences.
// RULE_10: One averaging count for every input.
// RULE_11: Ready flag only after full block.
// RULE_12: Clear accumulators on block start, restart.
`timescale 1ns/1ps
`include "cpacc_defines.svh"
module cpacc_engine
  import cpacc_pkg::*;
(
  input  wire logic                CLK_SYS,    // 250 MHz system clock.
  input  wire logic                NRST,       // Asynchronous reset, low.
  input  wire cpacc_pkg::cpacc_cfg_t CFG,      // Settings from registers.
  input  wire logic                CFG_WR,     // Settings written pulse.
  input  wire logic                ADC_DONE,   // Conversion done pulse.
  input  wire logic signed [15:0]  ADC_DATA,   // Converted sample.
  output logic                     ADC_START,  // Start conversion pulse.
  output logic [1:0]               ADC_SEL,    // Multiplexer input select.
  output cpacc_pkg::cpacc_res_t    RESULT,     // Averaged outputs.
  output logic                     RES_VALID,  // Outputs updated pulse.
  output logic                     CNV_READY,  // Conversion ready flag.
  output logic                     BUSY        // Sequence running.
);
  import cpacc_pkg::*;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1, // Waiting for a trigger.
    ST_PICK  = 4'h2, // Choose the next input.
    ST_CONV  = 4'h4, // Conversion in progress.
    ST_WRAP  = 4'h8  // Sample round finished.
  } cpacc_state_t;

  cpacc_state_t           state_reg, state_next;  // Sequencer state.
  logic [1:0]             sel_reg;                // Current mux input.
  logic [`CPACC_CNT_W-1:0] cnt_reg;               // Samples taken.
  logic signed [15:0]     shunt_reg;              // Latest shunt sample.
  logic signed [15:0]     bus_reg;                // Latest bus sample.
  logic                   got_shunt_reg;          // Shunt seen this round.
  logic                   got_bus_reg;            // Bus seen this round.
  logic signed [23:0]     cur_reg;                // Previous current.
  logic signed [`CPACC_ACC_W-1:0] acc_cur_reg;    // Current accumulator.
  logic signed [`CPACC_ACC_W-1:0] acc_pwr_reg;    // Power accumulator.
  logic                   pend_reg;               // Block end awaited.
  logic                   shot_done_reg;          // Single block finished.

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Number of samples for an averaging code, one to 1024.
  function automatic logic [`CPACC_CNT_W-1:0] avg_count(
      input logic [`CPACC_AVG_W-1:0] code);
    case (code)
      3'h0: avg_count = 11'h001;
      3'h1: avg_count = 11'h004;
      3'h2: avg_count = 11'h010;
      3'h3: avg_count = 11'h040;
      3'h4: avg_count = 11'h080;
      3'h5: avg_count = 11'h100;
      3'h6: avg_count = 11'h200;
      default: avg_count = 11'h400;
    endcase
  endfunction : avg_count

  // Right shift matching the power-of-two averaging count.
  function automatic logic [3:0] avg_shift(
      input logic [`CPACC_AVG_W-1:0] code);
    case (code)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'hA;
    endcase
  endfunction : avg_shift

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire run_mode   = (CFG.mode != `CPACC_MODE_OFF);
  wire restart    = CFG_WR; // RULE_12
  wire [1:0] next_sel =
      (sel_reg == `CPACC_SEL_SHUNT && CFG.en_bus)  ? `CPACC_SEL_BUS :
      (sel_reg != `CPACC_SEL_TEMP  && CFG.en_temp) ? `CPACC_SEL_TEMP :
      2'h3;                                 // 3 marks end of round.
  wire [1:0] first_sel =
      CFG.en_shunt ? `CPACC_SEL_SHUNT :
      CFG.en_bus   ? `CPACC_SEL_BUS   :
      CFG.en_temp  ? `CPACC_SEL_TEMP  : 2'h3;
  wire any_en     = CFG.en_shunt | CFG.en_bus | CFG.en_temp;
  wire [`CPACC_CNT_W-1:0] cnt_target = avg_count(CFG.avg_sel); // RULE_10
  wire round_end  = (state_reg == ST_WRAP);
  wire last_round = round_end && (cnt_reg + 11'h001 >= cnt_target);
  // Both halves of a pair seen: current and power may be formed.
  wire pair_ok    = round_end && got_shunt_reg && got_bus_reg; // RULE_01
  // A restart in the same cycle drops the pair, so no stale product
  // lands in the freshly cleared accumulators.
  wire calc_go    = pair_ok && !restart;

  // ----------------------------------------------------------------
  // Multiplier instances: current and power
  // ----------------------------------------------------------------
  logic signed [47:0] cur_prod;   // Shunt times calibration.
  logic               cur_done;   // Current product ready.
  logic signed [47:0] pwr_prod;   // Current times bus.
  logic               pwr_done;   // Power product ready.

  cpacc_mul u_cur_mul (
    .CLK_SYS  (CLK_SYS),
    .NRST     (NRST),
    .go       (calc_go),
    .a        ({{8{shunt_reg[15]}}, shunt_reg}),
    .b        ({8'h00, CFG.shunt_cal}),
    .p_reg    (cur_prod),
    .done_reg (cur_done)
  );

  // Power uses the current held from the previous pair.
  cpacc_mul u_pwr_mul (
    .CLK_SYS  (CLK_SYS),
    .NRST     (NRST),
    .go       (calc_go),
    .a        (cur_reg),                          // RULE_02
    .b        ({{8{bus_reg[15]}}, bus_reg}),
    .p_reg    (pwr_prod),
    .done_reg (pwr_done)
  );

  wire signed [23:0] cur_new = cur_prod[`CPACC_CUR_SHIFT+23:`CPACC_CUR_SHIFT];
  // A zero calibration forces the power sample to zero.
  wire signed [23:0] pwr_new =
      (CFG.shunt_cal == 16'h0000) ? 24'sh0 : pwr_prod[35:12]; // RULE_03
  wire [3:0] sh = avg_shift(CFG.avg_sel);
  wire signed [`CPACC_ACC_W-1:0] cur_sum =
      acc_cur_reg + {{26{cur_new[23]}}, cur_new};
  wire signed [`CPACC_ACC_W-1:0] pwr_sum =
      acc_pwr_reg + {{26{pwr_new[23]}}, pwr_new};
  wire signed [`CPACC_ACC_W-1:0] cur_avg = cur_sum >>> sh;
  wire signed [`CPACC_ACC_W-1:0] pwr_avg = pwr_sum >>> sh;

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  // Inputs are converted one after another through the mux.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (run_mode && any_en && !pend_reg && !shot_done_reg) begin
          state_next = ST_PICK;
        end
      end
      ST_PICK: state_next = ST_CONV;
      ST_CONV: begin
        if (ADC_DONE) begin
          state_next = (next_sel == 2'h3) ? ST_WRAP : ST_PICK; // RULE_08
        end
      end
      ST_WRAP: begin
        // Single mode stops after one block.
        if (last_round && CFG.mode != `CPACC_MODE_CONT) begin
          state_next = ST_IDLE; // RULE_09
        end else begin
          state_next = ST_PICK;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (restart) begin
      state_next = ST_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state_reg <= ST_IDLE;
      sel_reg   <= `CPACC_SEL_SHUNT;
      ADC_START <= 1'b0;
      ADC_SEL   <= `CPACC_SEL_SHUNT;
      BUSY      <= 1'b0;
      shot_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // A finished single block waits for the next settings write.
      if (restart) begin
        shot_done_reg <= 1'b0;
      end else if (last_round && CFG.mode != `CPACC_MODE_CONT) begin
        shot_done_reg <= 1'b1; // RULE_09
      end
      ADC_START <= (state_next == ST_PICK);
      BUSY      <= (state_next != ST_IDLE);
      if (state_reg == ST_IDLE || state_reg == ST_WRAP) begin
        sel_reg <= first_sel;
      end else if (state_reg == ST_CONV && ADC_DONE) begin
        sel_reg <= next_sel;
      end
      if (state_next == ST_PICK) begin
        ADC_SEL <= (state_reg == ST_CONV) ? next_sel :
                   (state_reg == ST_PICK) ? sel_reg : first_sel;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample capture and round counter
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      shunt_reg     <= 16'sh0;
      bus_reg       <= 16'sh0;
      got_shunt_reg <= 1'b0;
      got_bus_reg   <= 1'b0;
      cnt_reg       <= 11'h000;
    end else begin
      // A restart wins over a late done, so no half pair survives it.
      if (round_end || restart) begin
        got_shunt_reg <= 1'b0;
        got_bus_reg   <= 1'b0;
      end else if (state_reg == ST_CONV && ADC_DONE) begin
        if (sel_reg == `CPACC_SEL_SHUNT) begin
          shunt_reg     <= ADC_DATA;
          got_shunt_reg <= 1'b1;
        end
        if (sel_reg == `CPACC_SEL_BUS) begin
          bus_reg     <= ADC_DATA;
          got_bus_reg <= 1'b1;
        end
      end
      if (restart || (round_end && last_round)) begin
        cnt_reg <= 11'h000;
      end else if (round_end) begin
        cnt_reg <= cnt_reg + 11'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulate and publish
  // ----------------------------------------------------------------
  // Products arrive one cycle after the round ends, while the next
  // conversion already runs, so no time is added.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      cur_reg     <= 24'sh0;
      acc_cur_reg <= '0;
      acc_pwr_reg <= '0;
      pend_reg    <= 1'b0;
      RESULT      <= '0;
      RES_VALID   <= 1'b0;
      CNV_READY   <= 1'b0;
    end else begin
      RES_VALID <= 1'b0;
      if (calc_go && last_round) begin
        pend_reg <= 1'b1;
      end
      if (restart) begin
        acc_cur_reg <= '0;                              // RULE_12
        acc_pwr_reg <= '0;
        pend_reg    <= 1'b0;
        CNV_READY   <= 1'b0;
      end else if (cur_done && pwr_done) begin          // RULE_07
        cur_reg <= cur_new;
        if (pend_reg) begin
          // Block complete: averages go to the readable outputs.
          RESULT.current <= cur_avg[23:0];             // RULE_06
          RESULT.power   <= pwr_avg[23:0];
          RES_VALID      <= 1'b1;
          CNV_READY      <= 1'b1;                      // RULE_11
          acc_cur_reg    <= '0;                        // RULE_12
          acc_pwr_reg    <= '0;
          pend_reg       <= 1'b0;
        end else begin
          acc_cur_reg <= cur_sum;                      // RULE_04 RULE_05
          acc_pwr_reg <= pwr_sum;
        end
      end else if (last_round && !pair_ok) begin
        // No pair in this block: nothing to load, only the flag.
        CNV_READY <= 1'b1;                             // RULE_11
      end else if (state_reg == ST_PICK && cnt_reg == 11'h000
                   && !pend_reg) begin
        CNV_READY <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pair_product: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    calc_go |=> cur_done && pwr_done) // RULE_01
    else $error("Products missing after a completed pair.");
  a_zero_cal: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    RES_VALID && $past(CFG.shunt_cal) == 16'h0000 && $past(CFG.shunt_cal, 2)
      == 16'h0000 && $past(CFG.avg_sel) == 3'h0 |-> RESULT.power == 24'h0)
    // RULE_03
    else $error("Power not zero with zero calibration.");
  a_ready_valid: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    $rose(RES_VALID) |-> CNV_READY) // RULE_11
    else $error("Results loaded without ready flag.");
  a_restart_clr: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    restart |=> acc_cur_reg == 0 && acc_pwr_reg == 0 && !CNV_READY)
    // RULE_12
    else $error("Restart left accumulators or ready set.");
  a_one_input: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    ADC_START |-> state_reg == ST_PICK
      ##1 (state_reg == ST_CONV || $past(restart))) // RULE_08
    else $error("Conversion started outside the pick step.");
  a_single_stop: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    state_reg == ST_IDLE && shot_done_reg && !restart |=> !ADC_START)
    // RULE_09
    else $error("Single mode started again without a write.");
endmodule : cpacc_engine

//--- test/cpacc_adc_model.sv
// Behavioural model of the multiplexed converter that feeds the engine.
`timescale 1ns/1ps
`include "cpacc_defines.svh"
module cpacc_adc_model (
  input  wire logic               CLK_SYS,   // System clock.
  input  wire logic               NRST,      // Asynchronous reset, low.
  input  wire logic               ADC_START, // Start conversion pulse.
  input  wire logic [1:0]         ADC_SEL,   // Selected input.
  input  wire logic               ABORT,     // Restart drops conversion.
  input  wire logic [7:0]         LAT,       // Conversion length, cycles.
  input  wire logic signed [15:0] SHUNT_V,   // Shunt sample.
  input  wire logic signed [15:0] BUS_V,     // Bus sample.
  input  wire logic signed [15:0] TEMP_V,    // Temperature sample.
  output logic                    ADC_DONE,  // Conversion done pulse.
  output logic signed [15:0]      ADC_DATA   // Sample, valid with done.
);
  logic [7:0]         cnt_reg; // Cycles left in the conversion.
  logic [1:0]         sel_reg; // Input latched at start.
  logic signed [15:0] sample;  // Value of the latched input.
  assign sample = (sel_reg == `CPACC_SEL_SHUNT) ? SHUNT_V :
                  (sel_reg == `CPACC_SEL_BUS) ? BUS_V : TEMP_V;
  // Converts one input at a time; data toggles while not valid, so a
  // stale sample is never mistaken for a fresh one.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      cnt_reg  <= 8'h00;
      sel_reg  <= 2'h0;
      ADC_DONE <= 1'b0;
      ADC_DATA <= 16'h0000;
    end else begin
      ADC_DONE <= 1'b0;
      ADC_DATA <= ~ADC_DATA;
      if (ABORT) begin
        cnt_reg <= 8'h00;
      end else if (ADC_START) begin
        cnt_reg <= LAT;
        sel_reg <= ADC_SEL;
      end else if (cnt_reg == 8'h01) begin
        cnt_reg  <= 8'h00;
        ADC_DONE <= 1'b1;
        ADC_DATA <= sample;
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule : cpacc_adc_model

//--- test/cpacc_tb_top.sv
// Self-checking testbench of the current and power engine.
`timescale 1ns/1ps
`include "cpacc_defines.svh"
module cpacc_tb_top;
  import cpacc_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic               clk_sys;     // System clock.
  logic               nrst;        // Reset, active low.
  cpacc_cfg_t         cfg;         // Settings.
  logic               cfg_wr;      // Settings write pulse.
  logic               adc_done;    // From converter model.
  logic signed [15:0] adc_data;    // From converter model.
  logic               adc_start;   // To converter model.
  logic [1:0]         adc_sel;     // To converter model.
  cpacc_res_t         result;      // Averaged results.
  logic               res_valid;   // Result load pulse.
  logic               cnv_ready;   // Ready flag.
  logic               busy;        // Sequence running.
  logic [7:0]         lat;         // Converter speed.
  int                 miscompares; // Mismatches seen.
  int                 check_count; // Comparisons made.
  int                 cyc;         // Cycle counter.
  int                 done_cyc;    // Cycle of the last done.
  int                 starts;      // Conversion starts seen.
  int                 s0;          // Start count at a restart.
  int                 loads;       // Result loads seen.
  int                 l0;          // Load count at a restart.
  logic [1:0]         sel_q[$];    // Selected inputs in order.
  // ------------------------------------------------------------------
  // Design and converter model
  // ------------------------------------------------------------------
  cpacc_engine cpacc_engine_i (.CLK_SYS(clk_sys), .NRST(nrst), .CFG(cfg),
    .CFG_WR(cfg_wr), .ADC_DONE(adc_done), .ADC_DATA(adc_data),
    .ADC_START(adc_start), .ADC_SEL(adc_sel), .RESULT(result),
    .RES_VALID(res_valid), .CNV_READY(cnv_ready), .BUSY(busy));
  cpacc_adc_model cpacc_adc_model_i (.CLK_SYS(clk_sys), .NRST(nrst),
    .ADC_START(adc_start), .ADC_SEL(adc_sel), .ABORT(cfg_wr), .LAT(lat),
    .SHUNT_V(16'sh0400), .BUS_V(16'sh1000), .TEMP_V(16'sh0123),
    .ADC_DONE(adc_done), .ADC_DATA(adc_data));
  // Clock of 4 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Records starts, selected inputs and timing of conversions.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (adc_done) done_cyc <= cyc;
    if (res_valid) loads <= loads + 1;
    if (adc_start) begin
      starts <= starts + 1;
      sel_q.push_back(adc_sel);
    end
  end
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp,
                     input string what);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  // Writes settings with a one-cycle write pulse, then notes the starts.
  task automatic set_cfg(input logic [1:0] m, input logic [2:0] en,
                         input logic [2:0] avg, input logic [15:0] cal);
    @(posedge clk_sys);
    cfg    <= '{m, en[2], en[1], en[0], avg, cal};
    cfg_wr <= 1'b1;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    #1;
    s0 = starts;
    l0 = loads;
  endtask : set_cfg
  // Waits a bounded time for a result load.
  task automatic wait_valid(input int limit);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (res_valid !== 1'b1 && n < limit);
    chk(res_valid, 1'b1, "result load");
  endtask : wait_valid
  // Turns measuring off and expects the flags to drop.
  task automatic stop();
    set_cfg(`CPACC_MODE_OFF, 3'h0, 3'h0, 16'h0000);
    repeat (4) @(posedge clk_sys);
    #1;
    chk(busy, 1'b0, "busy off");
    chk(cnv_ready, 1'b0, "ready off");
  endtask : stop
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Continuous, no averaging, all inputs: order, power pairing, timing.
  task automatic s_cont();
    sel_q.delete();
    set_cfg(`CPACC_MODE_CONT, 3'h7, 3'h0, 16'h0800);
    wait_valid(400);
    chk(result.current, 24'h000400, "current");
    chk(result.power, 24'h000000, "power 1");
    chk(cnv_ready, 1'b1, "ready");
    chk(cyc - done_cyc <= 4, 1'b1, "latency");
    wait_valid(400);
    chk(result.power, 24'h000400, "power 2");
    for (int i = 0; i < 6; i++) begin
      chk(sel_q[i], 24'(i % 3), "select");
    end
    stop();
  endtask : s_cont
  // Zero calibration gives zero power.
  task automatic s_cal0();
    set_cfg(`CPACC_MODE_CONT, 3'h6, 3'h0, 16'h0000);
    wait_valid(400);
    wait_valid(400);
    chk(result.power, 24'h000000, "zero cal");
    stop();
  endtask : s_cal0
  // Single block of four samples on a slow converter.
  task automatic s_single();
    lat <= 8'h14;
    set_cfg(`CPACC_MODE_SINGLE, 3'h6, 3'h1, 16'h0800);
    wait_valid(2000);
    chk(24'(starts - s0), 24'h8, "starts");
    chk(result.current, 24'h000400, "avg cur");
    chk(result.power, 24'h000300, "avg pwr");
    repeat (100) @(posedge clk_sys);
    #1;
    chk(busy, 1'b0, "single done");
    chk(24'(starts - s0), 24'h8, "no more");
    chk(24'(loads - l0), 24'h1, "one load");
    lat <= 8'h05;
    stop();
  endtask : s_single
  // A write clears a standing ready; a mid-block restart clears sums.
  task automatic s_abort();
    set_cfg(`CPACC_MODE_SINGLE, 3'h6, 3'h1, 16'h0800);
    wait_valid(800);
    set_cfg(`CPACC_MODE_SINGLE, 3'h6, 3'h1, 16'h0800);
    chk(cnv_ready, 1'b0, "ready clear");
    for (int n = 0; n < 500 && starts - s0 < 3; n++) @(posedge clk_sys);
    set_cfg(`CPACC_MODE_CONT, 3'h6, 3'h1, 16'h0800);
    wait_valid(800);
    // Eight starts of the block plus the first of the next one.
    chk(24'(starts - s0), 24'h9, "restart");
    chk(result.current, 24'h000400, "fresh");
    chk(result.power, 24'h000400, "fresh pwr");
    stop();
  endtask : s_abort
  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    cfg = '0;
    cfg_wr = 1'b0;
    lat = 8'h05;
    miscompares = 0;
    check_count = 0;
    cyc = 0;
    done_cyc = 0;
    starts = 0;
    loads = 0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    s_cont();
    s_cal0();
    s_single();
    s_abort();
    finish_test();
  end
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
endmodule : cpacc_tb_top
